// ### verilog/odsfi_serial_port.sv
// Serial write port of an octal voltage-output converter.
// Assumes sclk comes from the host and stands still between frames, and
// that frame_n stays high for at least four clk cycles between frames.
`include "odsfi_defines.svh"

module odsfi_serial_port
   import odsfi_pkg::*;
(
   input  wire logic                        clk,
   input  wire logic                        nrst,
   input  wire logic                        sclk,
   input  wire logic                        frame_n,
   input  wire logic                        din,
   output logic                             dout,
   output logic [`ODSFI_WORD_BITS-1:0]      dac_word,
   output logic                             dac_update
);

   // Edge count of the current frame, held at a full word so that long
   // daisy frames cannot wrap back into the abort range.
   function automatic logic cnt_full(
      input logic [`ODSFI_CNT_BITS-1:0] v
   );
      return v == `ODSFI_COMMIT_EDGES;
   endfunction : cnt_full

   function automatic logic [`ODSFI_CNT_BITS-1:0] cnt_next(
      input logic [`ODSFI_CNT_BITS-1:0] v
   );
      logic [`ODSFI_CNT_BITS-1:0] r;
      if (cnt_full(v)) begin
         r = v;
      end else begin
         r = v + `ODSFI_CNT_BITS'(1);
      end
      return r;
   endfunction : cnt_next

   function automatic logic [`ODSFI_WORD_BITS-1:0] shift_in(
      input logic [`ODSFI_WORD_BITS-1:0] w,
      input logic                        b
   );
      return {w[`ODSFI_WORD_BITS-2:0], b};
   endfunction : shift_in

   function automatic logic word_msb(
      input logic [`ODSFI_WORD_BITS-1:0] w
   );
      return w[`ODSFI_WORD_BITS-1];
   endfunction : word_msb

   // Link domain: clocked by falling sclk; count and daisy bit cleared by frame_n high.
   logic [`ODSFI_WORD_BITS-1:0] shift_q;
   logic [`ODSFI_WORD_BITS-1:0] shift_d;
   logic [`ODSFI_CNT_BITS-1:0]  cnt_q;
   logic [`ODSFI_CNT_BITS-1:0]  cnt_d;
   logic                        dout_q;
   logic                        dout_d;
   logic                        frame_open;
   logic                        full_link;

   assign frame_open = !frame_n;
   assign full_link  = cnt_full(cnt_q);

   assign cnt_d = cnt_next(cnt_q);

   // The word is frozen while select is high, which is what lets the
   // system clock copy it after the synchronised rise without a handshake.
   assign shift_d = frame_open ? shift_in(shift_q, din)
                               : shift_q;

   // Bits leave from the top only once a full word sits in the register.
   assign dout_d = full_link ? word_msb(shift_q)
                             : dout_q;

   always_ff @(negedge sclk) begin
      shift_q <= shift_d;
   end

   // Cleared at once by the select rise, since sclk may not fall again.
   always_ff @(negedge sclk or posedge frame_n) begin
      if (frame_n) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   always_ff @(negedge sclk or posedge frame_n) begin
      if (frame_n) begin
         dout_q <= 1'b0;
      end else begin
         dout_q <= dout_d;
      end
   end

   // Frame state, full flag and daisy bit enter the clk domain together.
   // The daisy bit is resampled, so chaining at full sclk rate is lossy.
   odsfi_link_type link_c;
   odsfi_link_type sync_c;

   assign link_c.frame_act = frame_open;
   assign link_c.full      = full_link;
   assign link_c.daisy     = dout_q;

   odsfi_sync #(
      .WIDTH ($bits(odsfi_link_type))
   ) u_sync (
      .clk      (clk),
      .nrst     (nrst),
      .async_in (link_c),
      .sync_out (sync_c)
   );

   // System domain
   odsfi_state_type             state_q;
   odsfi_state_type             state_d;
   odsfi_commit_type            commit_c;
   logic [`ODSFI_WORD_BITS-1:0] word_d;
   logic                        frame_act_s;
   logic                        full_s;
   logic                        daisy_s;
   logic                        frame_close;
   logic                        commit;
   logic                        abort;
   logic                        upd_d;
   logic                        daisy_d;

   assign frame_act_s = sync_c.frame_act;
   assign full_s      = sync_c.full;
   assign daisy_s     = sync_c.daisy;
   assign frame_close = !frame_act_s;

   // The full flag must be seen while the frame is still open: the select
   // rise clears the count in the same instant that it arrives.
   assign commit = (state_q == ODSFI_FULL) && frame_close;

   // Fewer than sixteen edges, fifteen included, leave everything alone.
   assign abort = (state_q == ODSFI_SHIFT) && frame_close;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ODSFI_IDLE: begin
            if (frame_act_s) begin
               state_d = ODSFI_SHIFT;
            end
         end
         ODSFI_SHIFT: begin
            if (abort) begin
               state_d = ODSFI_IDLE;
            end else if (full_s) begin
               state_d = ODSFI_FULL;
            end
         end
         ODSFI_FULL: begin
            if (commit) begin
               state_d = ODSFI_IDLE;
            end
         end
         default: begin
            state_d = ODSFI_IDLE;
         end
      endcase
   end

   assign commit_c.valid = commit;
   assign commit_c.word  = shift_q;

   assign word_d  = commit_c.valid ? commit_c.word : dac_word;
   assign upd_d   = commit_c.valid;
   assign daisy_d = daisy_s && frame_act_s;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_q <= ODSFI_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         dac_word <= `ODSFI_WORD_RESET;
      end else begin
         dac_word <= word_d;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         dac_update <= 1'b0;
      end else begin
         dac_update <= upd_d;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         dout <= 1'b0;
      end else begin
         dout <= daisy_d;
      end
   end

endmodule : odsfi_serial_port

// ### include/odsfi_defines.svh
// Constants of the octal converter serial write port.
// Assumes inclusion by bare name from any design or bench file.
`ifndef ODSFI_DEFINES_SVH
`define ODSFI_DEFINES_SVH

`define ODSFI_WORD_BITS    16
`define ODSFI_CNT_BITS     5
`define ODSFI_COMMIT_EDGES 5'h10
`define ODSFI_WORD_RESET   16'h0000

`endif

// ### include/odsfi_pkg.sv
// Types shared by the serial write port and its bench.
// Assumes odsfi_defines.svh is on the include path.
`include "odsfi_defines.svh"

package odsfi_pkg;

   // Link-side status that crosses into the system clock together
   typedef struct packed {
      logic frame_act;
      logic full;
      logic daisy;
   } odsfi_link_type;

   typedef struct packed {
      logic                        valid;
      logic [`ODSFI_WORD_BITS-1:0] word;
   } odsfi_commit_type;

   typedef enum logic [1:0] {
      ODSFI_IDLE  = 2'b00,
      ODSFI_SHIFT = 2'b01,
      ODSFI_FULL  = 2'b10
   } odsfi_state_type;

endpackage : odsfi_pkg

// ### verilog/odsfi_sync.sv
// Two-flip-flop level synchroniser into the system clock domain.
// Assumes the source toggles slowly relative to clk.
module odsfi_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule : odsfi_sync

// ### tb/odsfi_serial_port_sva.sv
// Port checker for the serial write port.
// Assumes the design's top module ports only.
`include "odsfi_defines.svh"
module odsfi_serial_port_sva (
   input wire logic                        clk,
   input wire logic                        nrst,
   input wire logic                        frame_n,
   input wire logic                        dout,
   input wire logic [`ODSFI_WORD_BITS-1:0] dac_word,
   input wire logic                        dac_update
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   a_upd_gap: assert property (dac_update |=> !dac_update [*8])
      else $error("update pulse too long or too close");
   a_upd_after_rise: assert property (dac_update |-> $past(frame_n, 2))
      else $error("update without frame end");
   a_word_hold: assert property (!dac_update |-> $stable(dac_word))
      else $error("word changed without update");
   a_dout_late: assert property ($fell(frame_n) |-> !dout [*8])
      else $error("daisy output active early in frame");
   a_dout_idle: assert property (frame_n [*4] |=> !dout)
      else $error("daisy output active outside frame");
   a_rst_zero: assert property (disable iff (1'b0) !nrst |=>
      dac_word == '0 && !dac_update && !dout)
      else $error("outputs not cleared by reset");
endmodule : odsfi_serial_port_sva
bind odsfi_serial_port odsfi_serial_port_sva chk (.clk(clk), .nrst(nrst),
   .frame_n(frame_n), .dout(dout), .dac_word(dac_word),
   .dac_update(dac_update));

// ### tb/odsfi_host_model.sv
// Host side of the serial link: frame select, serial clock, data.
// Serial clock stands high between frames.
module odsfi_host_model;
   timeunit 1ns;
   timeprecision 1ps;
   logic sclk = 1'b1;
   logic frame_n = 1'b0;
   logic din = 1'b0;
   // Select rises once at power-up so the link count and daisy bit start cleared
   initial begin
      #1 frame_n = 1'b1;
   end
   task automatic send(input logic [31:0] w, input int n);
      frame_n = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         din = w[i];
         #15 sclk = 1'b0;
         #15 sclk = 1'b1;
      end
      #50 frame_n = 1'b1;
      din = ~din;
   endtask : send
endmodule : odsfi_host_model

// ### tb/octal_dac_serial_frame_input_tb_top.sv
// Self-checking bench for the serial write port.
// Assumes the host model drives the link side.
module octal_dac_serial_frame_input_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        dout;
   logic [15:0] dac_word;
   logic        dac_update;
   int          fail_count = 0;
   int          compares = 0;
   odsfi_host_model host ();
   odsfi_serial_port dut (.clk(clk), .nrst(nrst), .sclk(host.sclk),
      .frame_n(host.frame_n), .din(host.din), .dout(dout),
      .dac_word(dac_word), .dac_update(dac_update));
   initial begin
      forever #20 clk = ~clk;
   end
   task automatic check(input string n, input logic [15:0] s, e);
      compares++;
      if (s !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : check
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : report_and_stop
   // Bounded watch: a missing update pulse shows up as a flag mismatch
   task automatic frame(input logic [31:0] w, input int n,
                        input logic [15:0] e, input logic u);
      logic su = 1'b0;
      logic sd = 1'b0;
      fork
         host.send(w, n);
         repeat (n + 14) @(negedge clk) begin
            sd |= dout;
            su |= dac_update;
         end
      join
      check("flags", {14'h0, sd, su}, {14'h0, n > 16, u});
      check("word", dac_word, e);
      $display("frame of %0d edges done", n);
   endtask : frame
   task automatic apply_reset;
      nrst = 1'b0;
      repeat (8) @(negedge clk);
      nrst = 1'b1;
      check("reset word", dac_word, 16'h0000);
      repeat (4) @(negedge clk);
      $display("reset done");
   endtask : apply_reset
   initial begin
      apply_reset;
      frame(32'hA5C3, 16, 16'hA5C3, 1'b1);
      frame(32'h1234, 15, 16'hA5C3, 1'b0);
      frame(32'h0F0F, 9, 16'hA5C3, 1'b0);
      frame(32'hBEEF_0F0F, 32, 16'h0F0F, 1'b1);
      apply_reset;
      frame(32'h5A5A, 9, 16'h0000, 1'b0);
      report_and_stop;
   end
endmodule : octal_dac_serial_frame_input_tb_top
